// >>> verilog/vanc_insertion_scheduler.sv
// Purpose: Decide per field/frame which ancillary services are inserted
// Assumes: Video timing gives one-cycle field and frame pulses on aclk
// Notes:   Packet assembly lives downstream; this block emits the plan
`timescale 1ns/1ns
`include "vanc_sched_defines.svh"
`default_nettype none

// Notes on behaviour
// - Up to four services at once, each sourced from one of ten buffers.
// - Each service picks always, timed interval, or switch-state condition.
// - Always inserts every field when interlaced, every frame when progressive.
// - Timed and switch conditions use a per-service frame count.
// - Timed: insert count frames (one frame when count is zero), pause interval milliseconds, repeat forever.
// - Each switch input is open or closed; either may trigger a service.
// - Services sharing one switch state all start together.
// - Switch condition with zero count inserts forever after the state occurs.
// - Switch condition with nonzero count inserts exactly that many frames.
// - Default placement from buffer unless custom select chosen per item.
// - Report default line, channel, DID:SDID and field packet sizes.
// - Start command activates the selected service with its configuration.
// - Start with empty source deactivates the service.
// - Four switch inputs usable as conditions.
// - Track field and frame cadence for interlaced, progressive, segmented.
module vanc_insertion_scheduler (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        field_start,
    input  wire logic        frame_start,
    input  wire logic [3:0]  gpio_closed,
    output var  logic [3:0]  svc_insert,
    output var  logic [15:0] svc_buf_sel,
    output var  logic [43:0] svc_line,
    output var  logic [7:0]  svc_chan,
    output var  logic [63:0] svc_did_sdid
);
    localparam int NS = `NUM_SVC;
    localparam int NB = `NUM_BUF;

    // Per-buffer default placement: [10:0] line, [12:11] chan, [31:16] did:sdid
    logic [31:0] buf_place_reg [NB];
    logic [31:0] buf_place_next [NB];
    logic [31:0] buf_size_reg [NB];
    logic [31:0] buf_size_next [NB];
    // Per-service staged and active settings, and the video format
    logic [31:0] cfg_reg [NS];
    logic [31:0] cfg_next [NS];
    logic [31:0] act_reg [NS];
    logic [31:0] act_next [NS];
    logic [15:0] ivl_reg [NS];
    logic [15:0] ivl_next [NS];
    logic [2:0]  cus_reg [NS];
    logic [2:0]  cus_next [NS];
    logic [31:0] place_reg [NS];
    logic [31:0] place_next [NS];
    logic [1:0]  fmt_reg, fmt_next;
    logic [NS-1:0] run_reg, run_next;
    logic [NS-1:0] go_reg, go_next;
    // Scheduler state
    vanc_sched_pkg::phase_t ph_reg [NS];
    vanc_sched_pkg::phase_t ph_next [NS];
    logic [15:0] fcnt_reg [NS];
    logic [15:0] fcnt_next [NS];
    logic [15:0] ms_reg [NS];
    logic [15:0] ms_next [NS];
    logic [16:0] tick_reg, tick_next;
    // Bus state
    logic        aw_reg, aw_next, w_reg, w_next;
    logic [11:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;
    logic        awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, ardy_reg, ardy_next;
    // Switch input samples and registered outputs
    logic [3:0]  g_meta_reg, g_sync_reg, g_frame_reg, g_prev_reg;
    logic [3:0]  out_ins_reg, out_ins_next;
    logic [15:0] out_buf_reg, out_buf_next;
    logic [43:0] out_line_reg, out_line_next;
    logic [7:0]  out_chan_reg, out_chan_next;
    logic [63:0] out_id_reg, out_id_next;

    // Service index and offset of an address inside a service block
    function automatic logic svc_hit(input logic [11:0] a, output logic [1:0] s,
                                     output logic [4:0] o);
        logic [11:0] r;
        r = a - `OFS_SVC_BASE;
        s = r[6:5];
        o = r[4:0];
        return (a >= `OFS_SVC_BASE) && (r < 12'h080);
    endfunction : svc_hit

    function automatic logic buf_hit(input logic [11:0] a, output logic [3:0] b);
        logic [11:0] r;
        r = a - `OFS_BUF_BASE;
        b = r[6:3];
        return (a >= `OFS_BUF_BASE) && (r < 12'h050);
    endfunction : buf_hit

    wire logic aw_take = s_axi_awvalid && !aw_reg && !bv_reg;
    wire logic w_take  = s_axi_wvalid && !w_reg && !bv_reg;
    wire logic do_wr   = aw_reg && w_reg && !bv_reg;
    wire logic ms_tick = (tick_reg == 17'(`MS_CYCLES - 1));
    // Interlaced counts fields; progressive and segmented count frames
    wire logic cadence = (fmt_reg == 2'(vanc_sched_pkg::FMT_INTERLACED)) ?
                         field_start : frame_start;

    always_comb begin
        logic [1:0]  s;
        logic [4:0]  o;
        logic [3:0]  b;
        logic [31:0] m;
        logic        hit;
        s = 2'h0;
        o = 5'h0;
        b = 4'h0;
        hit = 1'b0;
        m = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
        buf_place_next = buf_place_reg;
        buf_size_next = buf_size_reg;
        cfg_next = cfg_reg;
        act_next = act_reg;
        ivl_next = ivl_reg;
        cus_next = cus_reg;
        place_next = place_reg;
        fmt_next = fmt_reg;
        run_next = run_reg;
        go_next = '0;
        aw_next = aw_reg | aw_take;
        w_next = w_reg | w_take;
        awa_next = aw_take ? s_axi_awaddr : awa_reg;
        wd_next = w_take ? s_axi_wdata : wd_reg;
        ws_next = w_take ? s_axi_wstrb : ws_reg;
        bv_next = bv_reg && !s_axi_bready;
        br_next = br_reg;
        rv_next = rv_reg && !s_axi_rready;
        rr_next = rr_reg;
        rd_next = rd_reg;
        if (do_wr) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = `AXI_OKAY;
            if (awa_reg == `OFS_CTRL) begin
                fmt_next = (wd_reg[1:0] & m[1:0]) | (fmt_reg & ~m[1:0]);
            end else if (awa_reg == `OFS_START) begin
                // Start latches staged config into the active set
                for (int i = 0; i < NS; i++) begin
                    if (wd_reg[i] && m[i]) begin
                        act_next[i] = cfg_reg[i];
                        run_next[i] = cfg_reg[i][3:0] < 4'(NB);
                        go_next[i] = 1'b1;
                    end
                end
            end else if (svc_hit(awa_reg, s, o)) begin
                case (o)
                    `SOFS_CFG:      cfg_next[s] = (wd_reg & m) | (cfg_reg[s] & ~m);
                    `SOFS_INTERVAL: ivl_next[s] = (wd_reg[15:0] & m[15:0]) |
                                                  (ivl_reg[s] & ~m[15:0]);
                    `SOFS_CUSTOM:   cus_next[s] = (wd_reg[2:0] & m[2:0]) |
                                                  (cus_reg[s] & ~m[2:0]);
                    `SOFS_PLACE:    place_next[s] = (wd_reg & m) | (place_reg[s] & ~m);
                    default:        br_next = `AXI_SLVERR;
                endcase
            end else if (buf_hit(awa_reg, b)) begin
                if (awa_reg[2])
                    buf_size_next[b] = (wd_reg & m) | (buf_size_reg[b] & ~m);
                else
                    buf_place_next[b] = (wd_reg & m) | (buf_place_reg[b] & ~m);
            end else begin
                br_next = `AXI_SLVERR;
            end
        end
        if (s_axi_arvalid && !rv_reg) begin
            rv_next = 1'b1;
            rr_next = `AXI_OKAY;
            rd_next = 32'h0;
            hit = svc_hit(s_axi_araddr, s, o);
            if (s_axi_araddr == `OFS_CTRL) begin
                rd_next = {30'h0, fmt_reg};
            end else if (s_axi_araddr == `OFS_STATUS) begin
                rd_next = {20'h0, out_ins_reg, 4'h0, run_reg};
            end else if (hit) begin
                b = cfg_reg[s][3:0] < 4'(NB) ? cfg_reg[s][3:0] : 4'h0;
                case (o)
                    `SOFS_CFG:      rd_next = cfg_reg[s];
                    `SOFS_INTERVAL: rd_next = {16'h0, ivl_reg[s]};
                    `SOFS_CUSTOM:   rd_next = {29'h0, cus_reg[s]};
                    `SOFS_PLACE:    rd_next = place_reg[s];
                    `SOFS_PREVIEW:  rd_next = buf_place_reg[b];
                    `SOFS_SIZE:     rd_next = buf_size_reg[b];
                    default:        rr_next = `AXI_SLVERR;
                endcase
            end else if (buf_hit(s_axi_araddr, b)) begin
                rd_next = s_axi_araddr[2] ? buf_size_reg[b] : buf_place_reg[b];
            end else begin
                rr_next = `AXI_SLVERR;
            end
        end
        // Readies registered, low while a channel is held or an answer waits
        awrdy_next = !aw_next && !bv_next;
        wrdy_next = !w_next && !bv_next;
        ardy_next = !rv_next;
    end

    // Scheduler: one phase machine per service
    always_comb begin
        logic [1:0]  gs;
        logic        want, hit_now;
        logic [15:0] fc;
        logic [31:0] pl;
        gs = 2'h0;
        want = 1'b0;
        hit_now = 1'b0;
        fc = 16'h0;
        pl = 32'h0;
        tick_next = ms_tick ? 17'h0 : tick_reg + 17'h1;
        out_ins_next = out_ins_reg;
        out_buf_next = out_buf_reg;
        out_line_next = out_line_reg;
        out_chan_next = out_chan_reg;
        out_id_next = out_id_reg;
        for (int i = 0; i < NS; i++) begin
            ph_next[i] = ph_reg[i];
            fcnt_next[i] = fcnt_reg[i];
            ms_next[i] = ms_reg[i];
            gs = act_reg[i][`CFG_GPIO_LSB +: 2];
            fc = act_reg[i][`CFG_FCNT_LSB +: 16];
            want = act_reg[i][`CFG_GSTATE_BIT];
            // New match only on the per-frame sample, shared by all services
            hit_now = (g_frame_reg[gs] == want) && (g_prev_reg[gs] != want);
            // Start restarts the phase machine so stale counts never carry over
            if (!run_reg[i] || go_reg[i]) begin
                ph_next[i] = vanc_sched_pkg::PH_IDLE;
            end else begin
                case (act_reg[i][`CFG_COND_LSB +: 2])
                    2'(vanc_sched_pkg::COND_ALWAYS): ph_next[i] = vanc_sched_pkg::PH_ON;
                    2'(vanc_sched_pkg::COND_TIMED): begin
                        case (ph_reg[i])
                            vanc_sched_pkg::PH_ON: if (frame_start) begin
                                if (fcnt_reg[i] <= 16'h1) begin
                                    ph_next[i] = vanc_sched_pkg::PH_WAIT;
                                    ms_next[i] = ivl_reg[i];
                                end
                                fcnt_next[i] = fcnt_reg[i] - 16'h1;
                            end
                            vanc_sched_pkg::PH_WAIT: begin
                                if (ms_reg[i] == 16'h0) begin
                                    ph_next[i] = vanc_sched_pkg::PH_ON;
                                    fcnt_next[i] = fc;
                                end else if (ms_tick) begin
                                    ms_next[i] = ms_reg[i] - 16'h1;
                                end
                            end
                            default: begin
                                ph_next[i] = vanc_sched_pkg::PH_ON;
                                fcnt_next[i] = fc;
                            end
                        endcase
                    end
                    2'(vanc_sched_pkg::COND_GPIO): begin
                        if (frame_start && hit_now) begin
                            ph_next[i] = vanc_sched_pkg::PH_ON;
                            fcnt_next[i] = fc;
                        end else if (frame_start && ph_reg[i] == vanc_sched_pkg::PH_ON
                                     && fcnt_reg[i] != 16'h0) begin
                            // Zero count never decrements: inserts forever
                            if (fcnt_reg[i] == 16'h1)
                                ph_next[i] = vanc_sched_pkg::PH_DONE;
                            fcnt_next[i] = fcnt_reg[i] - 16'h1;
                        end
                    end
                    default: ph_next[i] = vanc_sched_pkg::PH_IDLE;
                endcase
            end
            // Output decision taken on each cadence tick
            if (cadence) begin
                out_ins_next[i] = run_reg[i] && (ph_reg[i] == vanc_sched_pkg::PH_ON);
                pl = buf_place_reg[act_reg[i][3:0] < 4'(NB) ? act_reg[i][3:0] : 4'h0];
                out_buf_next[4*i +: 4] = act_reg[i][3:0] < 4'(NB) ?
                                         act_reg[i][3:0] : `SRC_NOTHING;
                out_line_next[11*i +: 11] = cus_reg[i][`CUS_LINE_BIT] ?
                                            place_reg[i][10:0] : pl[10:0];
                out_chan_next[2*i +: 2] = cus_reg[i][`CUS_CHAN_BIT] ?
                                          place_reg[i][12:11] : pl[12:11];
                out_id_next[16*i +: 16] = cus_reg[i][`CUS_DID_BIT] ?
                                          place_reg[i][31:16] : pl[31:16];
            end
        end
    end

    always_ff @(posedge aclk) begin
        // Two-flop sync, then one sample per frame
        g_meta_reg <= gpio_closed;
        g_sync_reg <= g_meta_reg;
        if (!aresetn) begin
            for (int k = 0; k < NB; k++) begin
                buf_place_reg[k] <= 32'h0;
                buf_size_reg[k] <= 32'h0;
            end
            for (int k = 0; k < NS; k++) begin
                cfg_reg[k] <= {28'h0, `SRC_NOTHING};
                act_reg[k] <= {28'h0, `SRC_NOTHING};
                ivl_reg[k] <= 16'h0;
                cus_reg[k] <= 3'h0;
                place_reg[k] <= 32'h0;
                ph_reg[k] <= vanc_sched_pkg::PH_IDLE;
                fcnt_reg[k] <= 16'h0;
                ms_reg[k] <= 16'h0;
            end
            fmt_reg <= 2'h0;
            run_reg <= '0;
            go_reg <= '0;
            tick_reg <= 17'h0;
            {aw_reg, w_reg, bv_reg, rv_reg} <= 4'h0;
            {awrdy_reg, wrdy_reg, ardy_reg} <= 3'h7;
            awa_reg <= 12'h0;
            wd_reg <= 32'h0;
            ws_reg <= 4'h0;
            br_reg <= 2'h0;
            rr_reg <= 2'h0;
            rd_reg <= 32'h0;
            g_frame_reg <= 4'h0;
            g_prev_reg <= 4'h0;
            out_ins_reg <= 4'h0;
            out_buf_reg <= 16'h0;
            out_line_reg <= 44'h0;
            out_chan_reg <= 8'h0;
            out_id_reg <= 64'h0;
        end else begin
            buf_place_reg <= buf_place_next;
            buf_size_reg <= buf_size_next;
            cfg_reg <= cfg_next;
            act_reg <= act_next;
            ivl_reg <= ivl_next;
            cus_reg <= cus_next;
            place_reg <= place_next;
            ph_reg <= ph_next;
            fcnt_reg <= fcnt_next;
            ms_reg <= ms_next;
            fmt_reg <= fmt_next;
            run_reg <= run_next;
            go_reg <= go_next;
            tick_reg <= tick_next;
            {aw_reg, w_reg, bv_reg, rv_reg} <= {aw_next, w_next, bv_next, rv_next};
            {awrdy_reg, wrdy_reg, ardy_reg} <= {awrdy_next, wrdy_next, ardy_next};
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            br_reg <= br_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
            if (frame_start) begin
                g_frame_reg <= g_sync_reg;
                g_prev_reg <= g_frame_reg;
            end
            out_ins_reg <= out_ins_next;
            out_buf_reg <= out_buf_next;
            out_line_reg <= out_line_next;
            out_chan_reg <= out_chan_next;
            out_id_reg <= out_id_next;
        end
    end

    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready = wrdy_reg;
    assign s_axi_arready = ardy_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rresp = rr_reg;
    assign s_axi_rdata = rd_reg;
    assign svc_insert = out_ins_reg;
    assign svc_buf_sel = out_buf_reg;
    assign svc_line = out_line_reg;
    assign svc_chan = out_chan_reg;
    assign svc_did_sdid = out_id_reg;
endmodule : vanc_insertion_scheduler

`default_nettype wire

// >>> verilog/vanc_sched_defines.svh
// Purpose: Constants for the ancillary insertion scheduler
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses
`ifndef VANC_SCHED_DEFINES_SVH
`define VANC_SCHED_DEFINES_SVH

`define NUM_SVC          4
`define NUM_BUF          10
`define NUM_GPIO         4
`define CLK_MHZ          100
`define MS_CYCLES        (`CLK_MHZ * 1000)

// Global registers
`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_START        12'h008
// Per-service block: base + 0x20 * service
`define OFS_SVC_BASE     12'h100
`define OFS_SVC_STRIDE   12'h020
`define SOFS_CFG         5'h00
`define SOFS_INTERVAL    5'h04
`define SOFS_CUSTOM      5'h08
`define SOFS_PLACE       5'h0c
`define SOFS_PREVIEW     5'h10
`define SOFS_SIZE        5'h14
// Per-buffer default placement table: base + 8 * buffer
`define OFS_BUF_BASE     12'h200
`define OFS_BUF_STRIDE   12'h008

// Service config fields
`define CFG_SRC_LSB      0
`define CFG_COND_LSB     4
`define CFG_GPIO_LSB     6
`define CFG_GSTATE_BIT   8
`define CFG_FCNT_LSB     16
// Custom selects
`define CUS_DID_BIT      0
`define CUS_LINE_BIT     1
`define CUS_CHAN_BIT     2

`define SRC_NOTHING      4'hf
`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10

`endif

// >>> verilog/vanc_sched_pkg.sv
// Purpose: Types for the ancillary insertion scheduler
// Assumes: Constants live in vanc_sched_defines.svh
// Notes:   Types only
package vanc_sched_pkg;
    typedef enum logic [1:0] {
        COND_ALWAYS = 2'b00,
        COND_TIMED  = 2'b01,
        COND_GPIO   = 2'b10
    } cond_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_ON    = 2'b01,
        PH_WAIT  = 2'b10,
        PH_DONE  = 2'b11
    } phase_t;

    typedef enum logic [1:0] {
        FMT_INTERLACED  = 2'b00,
        FMT_PROGRESSIVE = 2'b01,
        FMT_SEGMENTED   = 2'b10
    } fmt_t;
endpackage : vanc_sched_pkg

// >>> bench/vanc_video_model.sv
// Purpose: Video timing partner giving field and frame pulses
// Assumes: Two fields per frame, pulses one aclk wide
// Notes:   Frame kept short so runs stay brief
`timescale 1ns/1ns
`default_nettype none
module vanc_video_model #(
    parameter int FRAME_CYC = 200
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output var  logic field_start,
    output var  logic frame_start
);
    int cnt_reg;
    int cnt_next;
    always_comb begin
        cnt_next = (cnt_reg == FRAME_CYC - 1) ? 0 : cnt_reg + 1;
    end
    always_ff @(posedge aclk) begin
        cnt_reg <= aresetn ? cnt_next : 1;
        field_start <= aresetn && (cnt_next == 0 || cnt_next == FRAME_CYC / 2);
        frame_start <= aresetn && cnt_next == 0;
    end
endmodule : vanc_video_model
`default_nettype wire

// >>> bench/vanc_sched_props.sv
// Purpose: Port checks for the insertion scheduler
// Assumes: One aclk domain
// Notes:   Bound to every scheduler instance
`timescale 1ns/1ns
`default_nettype none
module vanc_sched_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        field_start,
    input wire logic        frame_start,
    input wire logic [3:0]  svc_insert,
    input wire logic [15:0] svc_buf_sel
);
    logic [3:0] idle_svc;
    logic [3:0] bad_sel;
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            idle_svc[s] = svc_buf_sel[4*s +: 4] == 4'hf;
            bad_sel[s]  = svc_buf_sel[4*s +: 4] > 4'h9 && !idle_svc[s];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    arready_inv_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after handshake");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == '0)
        else $error("error read returned data");
    insert_tick_a: assert property ($changed(svc_insert) |-> $past(field_start || frame_start))
        else $error("insert changed off cadence");
    idle_quiet_a: assert property ((svc_insert & idle_svc) == 4'h0)
        else $error("empty service inserting");
    buf_range_a: assert property (bad_sel == 4'h0)
        else $error("buffer select out of range");
endmodule : vanc_sched_props
bind vanc_insertion_scheduler vanc_sched_props vanc_sched_props_inst (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp,
    .s_axi_rdata, .field_start, .frame_start, .svc_insert, .svc_buf_sel);
`default_nettype wire

// >>> bench/vanc_insertion_scheduler_tb_top.sv
// Purpose: Register-driven scenarios for the insertion scheduler
// Assumes: Progressive cadence until the last scenario, frame every 200 cycles
// Notes:   Timed repeat not awaited; a millisecond exceeds the run
`timescale 1ns/1ns
`default_nettype none
module vanc_insertion_scheduler_tb_top;
    logic        aclk, aresetn, field_start, frame_start;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, gpio_closed, svc_insert;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] svc_buf_sel;
    logic [43:0] svc_line;
    logic [7:0]  svc_chan, fidx;
    logic [63:0] svc_did_sdid;
    logic [7:0]  hits [4];
    logic [7:0]  first [4];
    int          mismatches, total_checks, cyc;
    vanc_insertion_scheduler vanc_insertion_scheduler_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .field_start, .frame_start, .gpio_closed, .svc_insert,
        .svc_buf_sel, .svc_line, .svc_chan, .svc_did_sdid);
    vanc_video_model vanc_video_model_inst (.aclk, .aresetn, .field_start, .frame_start);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00,
                       input logic [3:0] st = 4'hf);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wstrb <= st;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {er, exp});
    endtask : axr
    // Sample five cycles after each frame start, well clear of the cadence update
    task automatic frames(input int n, input bit clr = 1'b1);
        if (clr) for (int s = 0; s < 4; s++) begin
            hits[s] = 8'h00;
            first[s] = 8'h00;
        end
        repeat (n) begin
            @(posedge frame_start);
            repeat (5) @(posedge aclk);
            fidx = fidx + 8'h01;
            for (int s = 0; s < 4; s++) begin
                hits[s] = hits[s] + 8'(svc_insert[s]);
                if (svc_insert[s] && first[s] == 8'h00) first[s] = fidx;
            end
        end
    endtask : frames
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gpio_closed, fidx} = '0;
        s_axi_wstrb = 4'hf;
        cyc = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk(svc_insert, 4'h0);
        axr(12'h000, 32'h0000_0000);
        axr(12'h100, 32'h0000_000f);
        axr(12'hffc, 32'h0000_0000, 2'b10);
        axw(12'hffc, 32'h1234_5678, 2'b10);
        axw(12'h000, 32'h0000_0001);
        axr(12'h000, 32'h0000_0001);
        axw(12'h000, 32'h0000_0002, 2'b00, 4'h0);
        axr(12'h000, 32'h0000_0001);
        axw(12'h218, 32'h5505_0809);
        axw(12'h21c, 32'h000e_000e);
        axw(12'h100, 32'h0000_0003);
        axw(12'h120, 32'h0000_0003);
        axw(12'h128, 32'h0000_0007);
        axw(12'h12c, 32'h0a0a_1014);
        axr(12'h110, 32'h5505_0809);
        axr(12'h114, 32'h000e_000e);
        axw(12'h008, 32'h0000_0003);
        frames(1);
        frames(4);
        chk({hits[0], hits[1]}, 16'h0404);
        chk({svc_line[21:0], svc_chan[3:0]}, {11'd20, 11'd9, 4'h9});
        chk({svc_did_sdid[31:0], svc_buf_sel[7:0]}, 40'h0a0a_5505_33);
        // Two services share one switch state, with different frame counts
        axw(12'h140, 32'h0002_01a5);
        axw(12'h160, 32'h0000_01a5);
        axw(12'h008, 32'h0000_000c);
        frames(3);
        chk({hits[2], hits[3]}, 16'h0000);
        @(posedge aclk);
        gpio_closed <= 4'h4;
        frames(8);
        chk(hits[2], 8'h02);
        chk(svc_insert[3], 1'b1);
        chk(first[2], first[3]);
        axw(12'h104, 32'h0000_0001);
        axw(12'h100, 32'h0002_0013);
        axw(12'h008, 32'h0000_0001);
        frames(6);
        chk(hits[0], 8'h02);
        axw(12'h100, 32'h0000_000f);
        axw(12'h008, 32'h0000_0001);
        frames(2);
        frames(3);
        chk({hits[0], hits[1]}, 16'h0003);
        chk(svc_buf_sel[3:0], 4'hf);
        axr(12'h004, 32'h0000_0a0e);
        // Interlaced: an always service must come on at the mid-frame field start
        axw(12'h000, 32'h0000_0000);
        axw(12'h100, 32'h0000_0003);
        axw(12'h008, 32'h0000_0001);
        @(posedge field_start);
        repeat (5) @(posedge aclk);
        chk(svc_insert[0], 1'b1);
        end_sim();
    end
endmodule : vanc_insertion_scheduler_tb_top
`default_nettype wire
